// ==== core/ddr2_mode_pkg.sv ====
// Shared constants for the mode register decode link and its controller.
// Assumes a single 125 MHz clock shared by both ends of the link.
package ddr2_mode_pkg;
    // Link command set; both ends sample on the same clock edge
    typedef enum logic [3:0] {
        cmd_nop, cmd_load_mode, cmd_activate, cmd_read, cmd_write_ap, cmd_refresh,
        cmd_precharge_all, cmd_self_refresh_enter, cmd_self_refresh_exit,
        cmd_power_down_enter, cmd_power_down_exit
    } cmd_t;
    // Controller-only operations beyond the plain link commands
    localparam logic [3:0] op_load_emr = 4'hC;
    localparam logic [3:0] op_calibrate = 4'hD;
    // Register image: bits 13..0 on the address lines, 16..14 on the bank lines
    localparam int reg_width = 17;
    localparam logic [2:0] bank_mode = 3'h0;
    localparam logic [2:0] bank_ext = 3'h1;
    // Base mode register fields
    localparam int cl_lsb = 4;
    localparam int dll_reset_bit = 8;
    localparam int wr_lsb = 9;
    localparam int pd_slow_bit = 12;
    // Extended mode register fields
    localparam int dll_off_bit = 0;
    localparam int drive_bit = 1;
    localparam int rtt_lo_bit = 2;
    localparam int rtt_hi_bit = 6;
    localparam int cal_lsb = 7;
    localparam int strobe_n_off_bit = 10;
    localparam int dup_strobe_bit = 11;
    localparam int out_off_bit = 12;
    localparam int ext_top_bit = 12;
    localparam logic [2:0] cal_default = 3'h7;
    // Termination codes {E6,E2}
    localparam logic [1:0] rtt_off = 2'h0;
    localparam logic [1:0] rtt_75 = 2'h1;
    localparam logic [1:0] rtt_150 = 2'h2;
    localparam logic [1:0] rtt_50 = 2'h3;
    // Timing
    localparam int clk_period_ns = 8;
    localparam int write_recovery_time_ns = 15;
    localparam int wr_clocks = (write_recovery_time_ns + clk_period_ns - 1) / clk_period_ns;
    localparam logic [3:0] wr_min = 4'h2;
    localparam logic [3:0] wr_max = 4'h8;
    localparam logic [2:0] cl_min = 3'h3;
    localparam logic [2:0] cl_max = 3'h7;
    localparam logic [1:0] burst_clocks = 2'h2;
    localparam logic [2:0] mode_set_delay = 3'h2;
    localparam logic [3:0] fast_powerdown_exit_time = 4'h2;
    localparam logic [3:0] slow_powerdown_exit_time = 4'h7;
    localparam logic [7:0] dll_lock_clocks = 8'hC8;
    localparam logic [3:0] odt_hold_clocks = 4'h8;
    // Controller register byte offsets and control register bit positions
    localparam logic [3:0] addr_mode = 4'h0;
    localparam logic [3:0] addr_ext = 4'h4;
    localparam logic [3:0] addr_control = 4'h8;
    localparam logic [3:0] addr_status = 4'hC;
    localparam int ctl_odt_bit = 8;
    localparam int ctl_slow_clk_bit = 9;
endpackage : ddr2_mode_pkg

// ==== core/ddr2_link_if.sv ====
// Command and address link between controller and memory device.
// Assumes both ends run on the same clk; no tristate wires are modelled.
interface ddr2_link_if;
    ddr2_mode_pkg::cmd_t cmd;
    logic [2:0] bank;
    logic [13:0] addr;
    logic odt;
    logic read_strobe;
    logic dup_read_strobe;
    modport device (
        input cmd, bank, addr, odt,
        output read_strobe, dup_read_strobe
    );
    modport controller (
        output cmd, bank, addr, odt,
        input read_strobe, dup_read_strobe
    );
endinterface : ddr2_link_if

// ==== core/ddr2_mode_device.sv ====
// Memory device end: mode and extended mode register decode and their effects.
// Assumes the controller keeps command spacing and reserved bits as required.
module ddr2_mode_device (
    input wire logic clk,
    input wire logic rst_n,
    ddr2_link_if.device link,
    output logic [2:0] read_latency_clocks,
    output logic [3:0] write_recovery_clocks,
    output logic mode_reserved,
    output logic internal_precharge,
    output logic row_open,
    output logic [1:0] power_state,
    output logic exit_busy,
    output logic dll_running,
    output logic dll_reset_pulse,
    output logic drive_reduced,
    output logic strobe_n_enable,
    output logic dup_strobe_enable,
    output logic dup_strobe_n_enable,
    output logic outputs_disabled,
    output logic [1:0] effective_termination,
    output logic termination_on
);
    typedef enum logic [1:0] {
        dev_active, dev_active_pd, dev_precharge_pd, dev_self_refresh
    } dev_state_t;

    logic [16:0] mode_register;
    logic [16:0] extended_mode_register;
    dev_state_t state;
    dev_state_t next_state;
    logic [7:0] read_pipe;
    logic [4:0] recovery_count;
    logic [3:0] exit_count;
    logic next_read_valid;

    // Raw field decode
    wire load_mr = link.cmd == ddr2_mode_pkg::cmd_load_mode
        && link.bank == ddr2_mode_pkg::bank_mode;
    wire load_emr = link.cmd == ddr2_mode_pkg::cmd_load_mode
        && link.bank == ddr2_mode_pkg::bank_ext;
    wire [2:0] cl_field = mode_register[ddr2_mode_pkg::cl_lsb +: 3];
    wire [2:0] wr_field = mode_register[ddr2_mode_pkg::wr_lsb +: 3];
    wire cl_ok = cl_field >= ddr2_mode_pkg::cl_min;
    wire wr_ok = wr_field != 3'h0;
    wire [3:0] wr_clk = {1'b0, wr_field} + 4'h1;
    wire slow_exit = mode_register[ddr2_mode_pkg::pd_slow_bit];
    wire [1:0] rtt_code = {extended_mode_register[ddr2_mode_pkg::rtt_hi_bit],
        extended_mode_register[ddr2_mode_pkg::rtt_lo_bit]};
    wire out_off = extended_mode_register[ddr2_mode_pkg::out_off_bit];
    wire strobe_n_on = ~extended_mode_register[ddr2_mode_pkg::strobe_n_off_bit];
    wire dup_on = extended_mode_register[ddr2_mode_pkg::dup_strobe_bit];
    wire dll_enabled = ~extended_mode_register[ddr2_mode_pkg::dll_off_bit];
    wire in_self_refresh = state == dev_self_refresh;
    wire frozen = state == dev_active_pd && slow_exit;
    wire is_read = link.cmd == ddr2_mode_pkg::cmd_read && state == dev_active;
    wire is_write_ap = link.cmd == ddr2_mode_pkg::cmd_write_ap && state == dev_active;
    // Last data lands write latency plus burst after the command
    wire [4:0] recovery_load = 5'({2'h0, cl_field} - 5'h1
        + {3'h0, ddr2_mode_pkg::burst_clocks} + {1'h0, wr_clk});
    // Exit bit only matters when a row is open
    wire [3:0] exit_load = (state == dev_active_pd && slow_exit)
        ? ddr2_mode_pkg::slow_powerdown_exit_time
        : ddr2_mode_pkg::fast_powerdown_exit_time;

    // Read data valid at edge n + read latency; pipe bit k is set after edge n+k
    always_comb begin
        next_read_valid = 1'b0;
        if (cl_ok) begin
            next_read_valid = read_pipe[cl_field - 3'h1];
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            dev_active: begin
                if (link.cmd == ddr2_mode_pkg::cmd_power_down_enter) begin
                    next_state = row_open ? dev_active_pd : dev_precharge_pd;
                end else if (link.cmd == ddr2_mode_pkg::cmd_self_refresh_enter) begin
                    next_state = dev_self_refresh;
                end
            end
            dev_active_pd, dev_precharge_pd: begin
                if (link.cmd == ddr2_mode_pkg::cmd_power_down_exit) begin
                    next_state = dev_active;
                end
            end
            dev_self_refresh: begin
                if (link.cmd == ddr2_mode_pkg::cmd_self_refresh_exit) begin
                    next_state = dev_active;
                end
            end
            default: next_state = dev_active;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_register <= 17'h00000;
            extended_mode_register <= 17'h00000;
        end else begin
            if (load_mr) begin
                mode_register <= {link.bank, link.addr};
            end else begin
                // Reset request bit clears itself after one clock
                mode_register[ddr2_mode_pkg::dll_reset_bit] <= 1'b0;
            end
            if (load_emr) begin
                extended_mode_register <= {link.bank, link.addr};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= dev_active;
            read_pipe <= 8'h00;
            recovery_count <= 5'h00;
            exit_count <= 4'h0;
            row_open <= 1'b0;
            internal_precharge <= 1'b0;
            exit_busy <= 1'b0;
            dll_reset_pulse <= 1'b0;
        end else begin
            state <= next_state;
            read_pipe <= {read_pipe[6:0], is_read};
            internal_precharge <= recovery_count == 5'h01;
            if (is_write_ap) begin
                recovery_count <= recovery_load;
            end else if (recovery_count != 5'h00) begin
                recovery_count <= recovery_count - 5'h01;
            end
            if (link.cmd == ddr2_mode_pkg::cmd_activate) begin
                row_open <= 1'b1;
            end else if (link.cmd == ddr2_mode_pkg::cmd_precharge_all
                || recovery_count == 5'h01) begin
                row_open <= 1'b0;
            end
            if (link.cmd == ddr2_mode_pkg::cmd_power_down_exit
                && (state == dev_active_pd || state == dev_precharge_pd)) begin
                exit_count <= exit_load;
            end else if (exit_count != 4'h0) begin
                exit_count <= exit_count - 4'h1;
            end
            exit_busy <= exit_count > 4'h1;
            // Reset on request and on leaving self refresh
            dll_reset_pulse <= (load_mr && link.addr[ddr2_mode_pkg::dll_reset_bit])
                || (in_self_refresh && next_state == dev_active);
        end
    end

    // Registered decode of the programmed fields
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            read_latency_clocks <= 3'h0;
            write_recovery_clocks <= 4'h0;
            mode_reserved <= 1'b1;
            power_state <= 2'h0;
            dll_running <= 1'b0;
            drive_reduced <= 1'b0;
            strobe_n_enable <= 1'b0;
            dup_strobe_enable <= 1'b0;
            dup_strobe_n_enable <= 1'b0;
            outputs_disabled <= 1'b0;
            effective_termination <= 2'h0;
            termination_on <= 1'b0;
            link.read_strobe <= 1'b0;
            link.dup_read_strobe <= 1'b0;
        end else begin
            read_latency_clocks <= cl_field;
            write_recovery_clocks <= wr_ok ? wr_clk : 4'h0;
            mode_reserved <= ~cl_ok || ~wr_ok;
            power_state <= state;
            dll_running <= dll_enabled && !in_self_refresh && !frozen;
            drive_reduced <= extended_mode_register[ddr2_mode_pkg::drive_bit];
            strobe_n_enable <= strobe_n_on && !out_off;
            dup_strobe_enable <= dup_on && !out_off;
            dup_strobe_n_enable <= dup_on && strobe_n_on && !out_off;
            outputs_disabled <= out_off;
            effective_termination <= rtt_code;
            termination_on <= rtt_code != ddr2_mode_pkg::rtt_off && link.odt
                && !in_self_refresh;
            link.read_strobe <= next_read_valid && !out_off;
            link.dup_read_strobe <= next_read_valid && dup_on && !out_off;
        end
    end
endmodule : ddr2_mode_device

// ==== core/ddr2_mode_controller.sv ====
// Controller end: software orders over Avalon-MM, issued as link commands.
// Assumes the link partner samples commands on the same clk edge.
module ddr2_mode_controller (
    input wire logic clk,
    input wire logic rst_n,
    ddr2_link_if.controller link,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest
);
    typedef enum logic [2:0] {
        ctl_idle, ctl_wait, ctl_calib_clear, ctl_dll_reset, ctl_pre_all
    } ctl_state_t;

    ctl_state_t state;
    ctl_state_t after_wait;
    logic [16:0] mode_shadow;
    logic [16:0] ext_shadow;
    logic odt_request;
    logic slow_clock;
    logic sr_mode;
    logic [2:0] wait_count;
    logic [7:0] lock_count;
    logic [3:0] odt_count;

    // Rounded-up recovery, never below the shortest legal setting
    function automatic int wr_clocks_c();
        return (ddr2_mode_pkg::wr_clocks < int'(ddr2_mode_pkg::wr_min))
            ? int'(ddr2_mode_pkg::wr_min) : ddr2_mode_pkg::wr_clocks;
    endfunction : wr_clocks_c

    localparam logic [2:0] wr_code = 3'(wr_clocks_c() - 1);

    wire [3:0] op = writedata[3:0];
    wire ctl_hit = address == ddr2_mode_pkg::addr_control;
    wire odt_high = link.odt;
    // Hold the order until it may legally be issued
    wire op_ready = state == ctl_idle
        && !(op == 4'(ddr2_mode_pkg::cmd_read) && lock_count != 8'h00)
        && !(op == 4'(ddr2_mode_pkg::cmd_self_refresh_enter) && odt_high);
    wire take = !waitrequest && (read || write);
    wire issue = take && write && ctl_hit && op != 4'h0;
    wire [16:0] mode_image = {4'h0, mode_shadow[12],
        wr_code, 1'b0, mode_shadow[7:0]};
    wire [16:0] ext_image = {4'h0, ext_shadow[12:10], 3'h0, ext_shadow[6:0]};
    wire ext_dll_on = !ext_shadow[ddr2_mode_pkg::dll_off_bit];
    wire ext_rtt_on = ext_shadow[ddr2_mode_pkg::rtt_hi_bit]
        || ext_shadow[ddr2_mode_pkg::rtt_lo_bit];

    // Register bus: one wait cycle, more while a control order is held, then a single-cycle acknowledge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end else if (!waitrequest) begin
            waitrequest <= 1'b1;
        end else if (read || (write && (!ctl_hit || op_ready))) begin
            waitrequest <= 1'b0;
            case (address)
                ddr2_mode_pkg::addr_mode: readdata <= {15'h0000, mode_shadow};
                ddr2_mode_pkg::addr_ext: readdata <= {15'h0000, ext_shadow};
                ddr2_mode_pkg::addr_control: readdata <= {22'h000000, slow_clock,
                    odt_request, 8'h00};
                ddr2_mode_pkg::addr_status: readdata <= {16'h0000, lock_count,
                    odt_count, 1'b0, sr_mode, odt_high, state != ctl_idle};
                default: readdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_shadow <= 17'h00000;
            ext_shadow <= 17'h00000;
            odt_request <= 1'b0;
            slow_clock <= 1'b0;
        end else if (take && write) begin
            if (address == ddr2_mode_pkg::addr_mode) begin
                mode_shadow <= writedata[16:0];
            end
            if (address == ddr2_mode_pkg::addr_ext) begin
                ext_shadow <= {4'h0, writedata[12:0]};
            end
            if (ctl_hit) begin
                odt_request <= writedata[ddr2_mode_pkg::ctl_odt_bit];
                slow_clock <= writedata[ddr2_mode_pkg::ctl_slow_clk_bit];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ctl_idle;
            after_wait <= ctl_idle;
            wait_count <= 3'h0;
            lock_count <= 8'h00;
            odt_count <= 4'h0;
            sr_mode <= 1'b0;
            link.cmd <= ddr2_mode_pkg::cmd_nop;
            link.bank <= 3'h0;
            link.addr <= 14'h0000;
            link.odt <= 1'b0;
        end else begin
            link.cmd <= ddr2_mode_pkg::cmd_nop;
            link.odt <= odt_request && !sr_mode && odt_count == 4'h0
                && !(state == ctl_idle && write && ctl_hit
                && op == 4'(ddr2_mode_pkg::cmd_self_refresh_enter));
            if (lock_count != 8'h00) begin
                lock_count <= lock_count - 8'h01;
            end
            if (odt_count != 4'h0) begin
                odt_count <= odt_count - 4'h1;
            end
            case (state)
                ctl_idle: begin
                    if (issue) begin
                        state <= ctl_wait;
                        after_wait <= ctl_idle;
                        wait_count <= 3'h1;
                        link.cmd <= ddr2_mode_pkg::cmd_t'(op);
                        if (op == 4'(ddr2_mode_pkg::cmd_load_mode)) begin
                            link.bank <= ddr2_mode_pkg::bank_mode;
                            {link.bank, link.addr} <= mode_image;
                            wait_count <= ddr2_mode_pkg::mode_set_delay;
                        end else if (op == ddr2_mode_pkg::op_load_emr
                            || op == ddr2_mode_pkg::op_calibrate) begin
                            link.cmd <= ddr2_mode_pkg::cmd_load_mode;
                            link.bank <= ddr2_mode_pkg::bank_ext;
                            link.addr <= (op == ddr2_mode_pkg::op_calibrate)
                                ? (ext_image[13:0]
                                | {4'h0, ddr2_mode_pkg::cal_default, 7'h00})
                                : ext_image[13:0];
                            wait_count <= ddr2_mode_pkg::mode_set_delay;
                            if (op == ddr2_mode_pkg::op_calibrate) begin
                                after_wait <= ctl_calib_clear;
                            end else if (ext_dll_on) begin
                                after_wait <= ctl_dll_reset;
                            end
                            if (ext_rtt_on) begin
                                odt_count <= ddr2_mode_pkg::odt_hold_clocks;
                            end
                        end else if (op == 4'(ddr2_mode_pkg::cmd_refresh)
                            && !ext_dll_on && slow_clock) begin
                            after_wait <= ctl_pre_all;
                        end else if (op == 4'(ddr2_mode_pkg::cmd_self_refresh_enter)) begin
                            sr_mode <= 1'b1;
                        end else if (op == 4'(ddr2_mode_pkg::cmd_self_refresh_exit)) begin
                            sr_mode <= 1'b0;
                            lock_count <= ddr2_mode_pkg::dll_lock_clocks;
                        end
                    end
                end
                ctl_wait: begin
                    if (wait_count <= 3'h1) begin
                        state <= after_wait;
                    end else begin
                        wait_count <= wait_count - 3'h1;
                    end
                end
                ctl_calib_clear: begin
                    link.cmd <= ddr2_mode_pkg::cmd_load_mode;
                    link.bank <= ddr2_mode_pkg::bank_ext;
                    link.addr <= ext_image[13:0];
                    wait_count <= ddr2_mode_pkg::mode_set_delay;
                    after_wait <= ext_dll_on ? ctl_dll_reset : ctl_idle;
                    state <= ctl_wait;
                end
                ctl_dll_reset: begin
                    link.cmd <= ddr2_mode_pkg::cmd_load_mode;
                    {link.bank, link.addr} <= mode_image
                        | (17'h00001 << ddr2_mode_pkg::dll_reset_bit);
                    lock_count <= ddr2_mode_pkg::dll_lock_clocks;
                    wait_count <= ddr2_mode_pkg::mode_set_delay;
                    after_wait <= ctl_idle;
                    state <= ctl_wait;
                end
                ctl_pre_all: begin
                    link.cmd <= ddr2_mode_pkg::cmd_precharge_all;
                    wait_count <= 3'h1;
                    after_wait <= ctl_idle;
                    state <= ctl_wait;
                end
                default: state <= ctl_idle;
            endcase
        end
    end
endmodule : ddr2_mode_controller

// ==== sim/ddr2_link_assertions.sv ====
// Checker for the command link joining controller and device.
// Assumes one clock for both ends and instantiation beside the link.
module ddr2_link_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire ddr2_mode_pkg::cmd_t cmd,
    input wire logic [2:0] bank,
    input wire logic [13:0] addr,
    input wire logic odt,
    input wire logic read_strobe,
    input wire logic dup_read_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] ext;
    logic [2:0] mcl;
    logic [7:0] lock;
    wire ld = cmd == ddr2_mode_pkg::cmd_load_mode;
    wire ld_ext = ld && bank == ddr2_mode_pkg::bank_ext;
    wire ld_dll = ld && bank == ddr2_mode_pkg::bank_mode && addr[8];
    // Shadow copies, since the decodes themselves are not on the link
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext <= 13'h0000;
            mcl <= 3'h0;
        end else if (ld_ext) begin
            ext <= addr[12:0];
        end else if (ld && bank == ddr2_mode_pkg::bank_mode) begin
            mcl <= addr[6:4];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) lock <= 8'h00;
        else if (ld_dll) lock <= ddr2_mode_pkg::dll_lock_clocks - 8'h01;
        else if (lock != 8'h00) lock <= lock - 8'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    read_lat_a: assert property (read_strobe && mcl == 3'h3 |-> $past(cmd, 4) == ddr2_mode_pkg::cmd_read)
        else $error("read strobe off its latency");
    mode_gap_a: assert property (ld |=> cmd == ddr2_mode_pkg::cmd_nop)
        else $error("command too soon after load");
    reserved_top_a: assert property (ld |-> bank[2] == 1'b0 && addr[13] == 1'b0)
        else $error("reserved load bits set");
    cal_bits_a: assert property (ld_ext |-> addr[9:7] == 3'h0 || addr[9:7] == 3'h7)
        else $error("calibration bits mixed");
    dll_reset_a: assert property (ld_ext && !addr[0] && addr[9:7] == 3'h0 |-> ##3 ld_dll)
        else $error("no DLL reset after enable");
    lock_wait_a: assert property (cmd == ddr2_mode_pkg::cmd_read |-> lock == 8'h00)
        else $error("read before DLL lock");
    dup_strobe_a: assert property (dup_read_strobe == (read_strobe && ext[11] && !ext[12]))
        else $error("duplicate strobe wrong");
    odt_hold_a: assert property (ld_ext && (addr[6] || addr[2]) |=> !odt [*8])
        else $error("termination pin high too early");
endmodule : ddr2_link_assertions

// ==== sim/tb.sv ====
// Testbench joining controller and device over the command link.
// Assumes a 125 MHz clock; every order goes through the Avalon-MM slave.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata, rdata;
    logic waitrequest, drv_red, dup_en, strobe_n_en, term_on;
    logic [2:0] cl_out;
    logic [3:0] wr_out;
    logic [1:0] rtt;
    logic [1:0] pwr;
    logic mode_res, dll_run, dup_n_en, out_dis;
    int errors = 0;
    int checked = 0;
    ddr2_link_if link ();
    ddr2_mode_controller u_ddr2_mode_controller (.clk(clk), .rst_n(rst_n), .link(link),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest));
    ddr2_mode_device u_ddr2_mode_device (.clk(clk), .rst_n(rst_n), .link(link),
        .read_latency_clocks(cl_out), .write_recovery_clocks(wr_out), .mode_reserved(mode_res),
        .internal_precharge(), .row_open(), .power_state(pwr), .exit_busy(), .dll_running(dll_run),
        .dll_reset_pulse(), .drive_reduced(drv_red), .strobe_n_enable(strobe_n_en),
        .dup_strobe_enable(dup_en), .dup_strobe_n_enable(dup_n_en), .outputs_disabled(out_dis),
        .effective_termination(rtt), .termination_on(term_on));
    ddr2_link_assertions u_ddr2_link_assertions (.clk(clk), .rst_n(rst_n), .cmd(link.cmd),
        .bank(link.bank), .addr(link.addr), .odt(link.odt), .read_strobe(link.read_strobe),
        .dup_read_strobe(link.dup_read_strobe));
    task automatic stop_test();
        if (errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Waits out the whole read hold; the bound covers the 200-clock lock
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 2000);
        if (waitrequest !== 1'b0) begin
            errors++;
            stop_test();
        end
        rdata = readdata;
        write <= 1'b0;
        read <= 1'b0;
        // Idle edge so the next call never reassigns in this time step
        @(posedge clk);
    endtask : bus
    task automatic order(input logic [31:0] d);
        int n;
        n = 0;
        bus(1'b1, ddr2_mode_pkg::addr_control, d);
        do begin
            bus(1'b0, ddr2_mode_pkg::addr_status, 32'h00000000);
            n++;
        end while (rdata[0] !== 1'b0 && n < 500);
        if (rdata[0] !== 1'b0) begin
            errors++;
            stop_test();
        end
        repeat (3) @(posedge clk);
    endtask : order
    task automatic t_mode();
        bus(1'b1, ddr2_mode_pkg::addr_mode, 32'h00001E30);
        order(32'h00000001);
        check(cl_out, 32'h3);
        check(wr_out, 32'h2);
        check(mode_res, 32'h0);
        bus(1'b0, 4'h2, 32'h00000000);
        check(rdata, 32'h0);
    endtask : t_mode
    task automatic t_ext();
        bus(1'b1, ddr2_mode_pkg::addr_ext, 32'h00000846);
        order(32'h0000010C);
        check(drv_red, 32'h1);
        check(rtt, ddr2_mode_pkg::rtt_50);
        check(dup_en, 32'h1);
        check(strobe_n_en, 32'h1);
        check(dup_n_en, 32'h1);
        check(out_dis, 32'h0);
        repeat (10) @(posedge clk);
        check(term_on, 32'h1);
        check(dll_run, 32'h1);
    endtask : t_ext
    task automatic t_read();
        int n;
        n = 0;
        order(32'h00000102);
        bus(1'b1, ddr2_mode_pkg::addr_control, 32'h00000103);
        // Read registered at the return edge; strobe flop seen one edge after n + 3
        while (link.read_strobe !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        check(n, 32'h4);
        check(link.dup_read_strobe, 32'h1);
        order(32'h00000109);
        check(pwr, 32'h1);
        check(dll_run, 32'h0);
    endtask : t_read
    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_mode();
        t_ext();
        t_read();
        stop_test();
    end
endmodule : tb
